// ===== shared/drx_pkg.sv
// Package for the dual-channel receive status register bank.
// Assumes one core clock shared by the receiver, the register port and this bank.
package drx_pkg;

	// ****************************************
	// Register offsets
	// ****************************************
	localparam logic [7:0] DRX_ADDR_EVENT_FLAGS = 8'h08;
	localparam logic [7:0] DRX_ADDR_A_BYTE = 8'h09;
	localparam logic [7:0] DRX_ADDR_A_MASK = 8'h0a;
	localparam logic [7:0] DRX_ADDR_B_BYTE = 8'h0b;

	// ****************************************
	// Reset values and field layout
	// ****************************************
	localparam logic [7:0] DRX_RST_BYTE = 8'h00;
	localparam logic [7:0] DRX_RD_ZERO = 8'h00;
	localparam int DRX_CHANNELS = 2;
	localparam int DRX_FLAGS_PER_CH = 4;
	localparam int DRX_BIT_FULL = 0;
	localparam int DRX_BIT_EOF = 1;
	localparam int DRX_BIT_FLOW = 2;
	localparam int DRX_BIT_VALID = 3;
	localparam logic [7:0] DRX_IRQ_CAPABLE = 8'h77;
	localparam int DRX_BYTE_BITS = 8;
	localparam int DRX_EOF_LEN_W = 4;
	localparam int DRX_FIFO_DEPTH = 32;
	localparam int DRX_FIFO_WIDTH = 2;

endpackage

// ===== logic/drx_fifo.sv
// Flip-flop FIFO holding received bit samples ahead of the byte packer.
// Assumes both sides run on clk; ready and valid follow the usual handshake.
`timescale 1ns/100ps
module drx_fifo #(
	parameter int WIDTH = 2,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	localparam logic [AW:0] DEPTH_C = AW'(DEPTH - 1) + 1'b1;

	logic [WIDTH-1:0] mem_ff [DEPTH];
	logic [AW-1:0] wr_ptr_ff;
	logic [AW-1:0] rd_ptr_ff;
	logic [AW:0] count_ff;
	logic [AW:0] nxt_count;
	logic push;
	logic pop;

	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_ff[rd_ptr_ff];

	always_comb begin
		nxt_count = count_ff;
		if (push && !pop) begin
			nxt_count = count_ff + 1'b1;
		end else if (pop && !push) begin
			nxt_count = count_ff - 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (push) begin
			mem_ff[wr_ptr_ff] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			count_ff <= '0;
			in_ready <= 1'b0;
			out_valid <= 1'b0;
		end else begin
			if (push) begin
				wr_ptr_ff <= (wr_ptr_ff == AW'(DEPTH - 1)) ? '0 : wr_ptr_ff + 1'b1;
			end
			if (pop) begin
				rd_ptr_ff <= (rd_ptr_ff == AW'(DEPTH - 1)) ? '0 : rd_ptr_ff + 1'b1;
			end
			count_ff <= nxt_count;
			in_ready <= (nxt_count != DEPTH_C);
			out_valid <= (nxt_count != '0);
		end
	end

endmodule // drx_fifo

// ===== logic/drx_status_regs.sv
// Receive status and holding registers for two receive channels, validity register for channel A.
// Assumes the receiver delivers one bit sample per strobe and the register
// port gives one-cycle read and write strobes on clk.
`timescale 1ns/100ps
module drx_status_regs
	import drx_pkg::*;
#(
	parameter int FIFO_DEPTH = drx_pkg::DRX_FIFO_DEPTH
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [drx_pkg::DRX_CHANNELS-1:0] bit_strobe,
	input wire logic [drx_pkg::DRX_CHANNELS-1:0] bit_data,
	input wire logic [drx_pkg::DRX_CHANNELS-1:0] bit_valid,
	output logic [drx_pkg::DRX_CHANNELS-1:0] bit_ready,
	input wire logic rx_enable,
	input wire logic tx_enable,
	input wire logic [drx_pkg::DRX_EOF_LEN_W-1:0] eof_length,
	input wire logic [7:0] irq_enable,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic reg_wr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic irq
);
	import drx_pkg::*;

	// ****************************************
	// Shared decode
	// ****************************************
	logic rx_mode;
	logic rd_status;
	logic [7:0] flags;
	logic [7:0] hold_byte_ff [DRX_CHANNELS];
	logic [7:0] hold_mask_ff [DRX_CHANNELS];
	logic [DRX_CHANNELS-1:0] rd_byte;

	assign rx_mode = rx_enable && !tx_enable;
	assign rd_status = reg_rd && (reg_addr == DRX_ADDR_EVENT_FLAGS);
	assign rd_byte[0] = reg_rd && (reg_addr == DRX_ADDR_A_BYTE);
	assign rd_byte[1] = reg_rd && (reg_addr == DRX_ADDR_B_BYTE);

	// ****************************************
	// Per-channel packer and flags
	// ****************************************
	genvar ch;
	generate
		for (ch = 0; ch < DRX_CHANNELS; ch++) begin : g_ch
			localparam int FB = ch * DRX_FLAGS_PER_CH;
			logic [1:0] smp;
			logic smp_valid;
			logic take;
			logic [7:0] shift_ff;
			logic [7:0] mask_ff;
			logic [3:0] cnt_ff;
			logic started_ff;
			logic [DRX_EOF_LEN_W:0] inv_ff;
			logic occupied_ff;
			logic full_ff;
			logic eof_ff;
			logic flow_ff;
			logic allv_ff;
			logic [7:0] nxt_shift;
			logic [7:0] nxt_mask;
			logic [3:0] nxt_cnt;
			logic [DRX_EOF_LEN_W:0] nxt_inv;
			logic frame_end;
			logic land;

			// Drain stalls outside receive mode so the FIFO holds samples
			drx_fifo #(
				.WIDTH(DRX_FIFO_WIDTH),
				.DEPTH(FIFO_DEPTH)
			) u_fifo (
				.clk(clk),
				.rstn(rstn),
				.in_valid(bit_strobe[ch]),
				.in_ready(bit_ready[ch]),
				.in_data({bit_valid[ch], bit_data[ch]}),
				.out_valid(smp_valid),
				.out_ready(rx_mode),
				.out_data(smp)
			);

			assign take = smp_valid && rx_mode;

			always_comb begin
				nxt_shift = shift_ff;
				nxt_mask = mask_ff;
				nxt_shift[cnt_ff[2:0]] = smp[0];
				nxt_mask[cnt_ff[2:0]] = smp[1];
				nxt_cnt = cnt_ff + 1'b1;
				nxt_inv = smp[1] ? '0 : inv_ff + 1'b1;
				// Invalid run exceeding the length ends the frame; zero ends at first
				frame_end = take && started_ff && !smp[1]
					&& (nxt_inv > {1'b0, eof_length});
				land = take && (nxt_cnt == 4'(DRX_BYTE_BITS) || frame_end);
			end

			always_ff @(posedge clk) begin
				if (!rstn) begin
					shift_ff <= DRX_RST_BYTE;
					mask_ff <= DRX_RST_BYTE;
					cnt_ff <= '0;
					started_ff <= 1'b0;
					inv_ff <= '0;
				end else if (take) begin
					if (land) begin
						shift_ff <= DRX_RST_BYTE;
						mask_ff <= DRX_RST_BYTE;
						cnt_ff <= '0;
					end else begin
						shift_ff <= nxt_shift;
						mask_ff <= nxt_mask;
						cnt_ff <= nxt_cnt;
					end
					started_ff <= frame_end ? 1'b0 : (started_ff || smp[1]);
					inv_ff <= (frame_end || !started_ff) ? '0 : nxt_inv;
				end
			end

			always_ff @(posedge clk) begin
				if (!rstn) begin
					hold_byte_ff[ch] <= DRX_RST_BYTE;
					hold_mask_ff[ch] <= DRX_RST_BYTE;
					allv_ff <= 1'b0;
				end else if (land) begin
					hold_byte_ff[ch] <= nxt_shift;
					hold_mask_ff[ch] <= nxt_mask;
					allv_ff <= &nxt_mask;
				end
			end

			// Occupancy: landing fills, host read empties; landing wins
			always_ff @(posedge clk) begin
				if (!rstn) begin
					occupied_ff <= 1'b0;
				end else if (land) begin
					occupied_ff <= 1'b1;
				end else if (rd_byte[ch]) begin
					occupied_ff <= 1'b0;
				end
			end

			always_ff @(posedge clk) begin
				if (!rstn) begin
					full_ff <= 1'b0;
				end else if (land) begin
					full_ff <= 1'b1;
				end else if (rd_byte[ch]) begin
					full_ff <= 1'b0;
				end
			end

			always_ff @(posedge clk) begin
				if (!rstn) begin
					eof_ff <= 1'b0;
				end else if (frame_end) begin
					eof_ff <= 1'b1;
				end else if (rd_status) begin
					eof_ff <= 1'b0;
				end
			end

			always_ff @(posedge clk) begin
				if (!rstn) begin
					flow_ff <= 1'b0;
				end else if (land && occupied_ff && !rd_byte[ch]) begin
					flow_ff <= 1'b1;
				end else if (rd_byte[ch] && !occupied_ff) begin
					flow_ff <= 1'b1;
				end else if (rd_status) begin
					flow_ff <= 1'b0;
				end
			end

			assign flags[FB + DRX_BIT_FULL] = full_ff;
			assign flags[FB + DRX_BIT_EOF] = eof_ff;
			assign flags[FB + DRX_BIT_FLOW] = flow_ff;
			assign flags[FB + DRX_BIT_VALID] = allv_ff;
		end
	endgenerate

	// ****************************************
	// Register read port
	// ****************************************
	// Writes are decoded nowhere: every register here is read-only
	logic unused_wr;
	assign unused_wr = reg_wr ^ (|reg_wdata);

	always_ff @(posedge clk) begin
		if (!rstn) begin
			reg_rdata <= DRX_RD_ZERO;
		end else if (reg_rd) begin
			case (reg_addr)
				DRX_ADDR_EVENT_FLAGS: reg_rdata <= rx_mode ? flags : DRX_RD_ZERO;
				DRX_ADDR_A_BYTE: reg_rdata <= hold_byte_ff[0];
				DRX_ADDR_A_MASK: reg_rdata <= hold_mask_ff[0];
				DRX_ADDR_B_BYTE: reg_rdata <= hold_byte_ff[1];
				default: reg_rdata <= DRX_RD_ZERO;
			endcase
		end
	end

	// ****************************************
	// Interrupt request
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= rx_mode && |(flags & irq_enable & DRX_IRQ_CAPABLE);
		end
	end

endmodule // drx_status_regs

// ===== testbench/drx_status_regs_sva.sv
// Port checker for the receive status bank.
// Assumes one clock and a bind onto drx_status_regs.
`timescale 1ns/100ps
module drx_sva (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [1:0] bit_strobe,
	input wire logic [1:0] bit_ready,
	input wire logic rx_enable,
	input wire logic tx_enable,
	input wire logic [7:0] irq_enable,
	input wire logic [7:0] reg_addr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic irq
);
	// ********
	// Checks
	// ********
	wire rxm = rx_enable && !tx_enable;
	wire rds = reg_rd && reg_addr == 8'h08;
	wire idl = bit_strobe == 2'b00 && rxm;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	AST_RST_ZERO: assert property ($rose(rstn) |-> reg_rdata == 8'h00 && !irq)
		else $error("rdata or irq set after reset");
	AST_IDLE_READ: assert property (rds && !rxm |=> reg_rdata == 8'h00)
		else $error("status nonzero outside receive mode");
	AST_IDLE_IRQ: assert property (!rxm |=> !irq)
		else $error("irq outside receive mode");
	AST_IRQ_EN: assert property ($rose(irq) |-> ($past(irq_enable) & 8'h77) != 8'h00)
		else $error("irq without enable");
	AST_VALID_IRQ: assert property (((irq_enable & 8'h77) == 8'h00)[*2] |-> !irq)
		else $error("irq from all-valid flag");
	AST_RD_HOLD: assert property (!reg_rd |=> $stable(reg_rdata))
		else $error("rdata moved without read");
	AST_UNMAPPED: assert property (reg_rd && reg_addr > 8'h0b |=> reg_rdata == 8'h00)
		else $error("unmapped read nonzero");
	AST_RD_CLEAR: assert property (idl[*8] ##1 idl[*8] ##1 rds ##2 rds
		|=> (reg_rdata & 8'h66) == 8'h00) else $error("flags kept after read");
	cover property (rds && rxm ##1 reg_rdata[0]);
	cover property ($rose(irq));
	cover property (bit_strobe[0] && !bit_ready[0]);
endmodule // drx_sva
bind drx_status_regs drx_sva drx_sva_i (.*);

// ===== testbench/drx_host_model.sv
// Host model on the register port.
// Assumes reg_rdata answers one edge after the read.
`timescale 1ns/100ps
module drx_host_model (
	input wire logic clk,
	output logic [7:0] reg_addr,
	output logic reg_rd,
	output logic reg_wr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	// ********
	// Accesses
	// ********
	initial begin
		reg_addr = 8'h00;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
		reg_wdata = 8'h00;
	end
	task automatic access(input logic [7:0] a, input logic w, output logic [7:0] d);
		@(negedge clk);
		reg_addr = a;
		reg_rd = !w;
		reg_wr = w;
		reg_wdata = 8'h5a;
		@(negedge clk);
		d = reg_rdata;
		reg_rd = 1'b0;
		reg_wr = 1'b0;
	endtask
	task automatic read_a(output logic [7:0] st, output logic [7:0] dt, output logic [7:0] mk);
		access(8'h08, 1'b0, st);
		access(8'h09, 1'b0, dt);
		if (st[3]) mk = 8'hff;
		else access(8'h0a, 1'b0, mk);
	endtask
endmodule // drx_host_model

// ===== testbench/dual_rx_serial_byte_packer_status_regs_tb.sv
// Self-checking bench for the receive status bank.
// Assumes the host model owns the register port.
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
	$display("MISMATCH %s exp %h got %h", n, e, g); end end
module dual_rx_serial_byte_packer_status_regs_tb;
	// ********
	// Bench
	// ********
	typedef struct {int ch; int n; logic [3:0] l; logic [7:0] dat, vld, st, byt, msk;} drx_row_t;
	logic clk, rstn, rx_enable, tx_enable, irq, reg_rd, reg_wr;
	logic [1:0] bit_strobe, bit_data, bit_valid, bit_ready;
	logic [3:0] eof_length;
	logic [7:0] irq_enable, reg_addr, reg_wdata, reg_rdata, d, st, dt, mk;
	int error_cnt = 0;
	int n_tests = 0;
	int k;
	drx_row_t rows [5] = '{'{0, 8, 4'h0, 8'ha5, 8'hff, 8'h09, 8'ha5, 8'hff},
		'{1, 8, 4'h0, 8'h3c, 8'hff, 8'h98, 8'h3c, 8'h00},
		'{0, 3, 4'h0, 8'h06, 8'h03, 8'h83, 8'h06, 8'h03},
		'{1, 2, 4'h0, 8'h01, 8'h01, 8'h30, 8'h01, 8'h00},
		'{0, 4, 4'h2, 8'h09, 8'h01, 8'h03, 8'h09, 8'h01}};
	drx_status_regs #(.FIFO_DEPTH(4)) drx_status_regs_i (.clk(clk), .rstn(rstn),
		.bit_strobe(bit_strobe), .bit_data(bit_data), .bit_valid(bit_valid),
		.bit_ready(bit_ready), .rx_enable(rx_enable), .tx_enable(tx_enable),
		.eof_length(eof_length), .irq_enable(irq_enable), .reg_addr(reg_addr),
		.reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .irq(irq));
	drx_host_model drx_host_model_i (.clk(clk), .reg_addr(reg_addr), .reg_rd(reg_rd),
		.reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic idle(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic chk_rd(input logic [7:0] a, input logic [7:0] e);
		drx_host_model_i.access(a, 1'b0, d);
		`CHK("rdata", e, d)
	endtask
	task automatic push(input int ch, input logic [7:0] dv, input logic [7:0] vl, input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge clk);
			while (!bit_ready[ch]) @(negedge clk);
			bit_strobe[ch] = 1'b1;
			bit_data[ch] = dv[i];
			bit_valid[ch] = vl[i];
			@(negedge clk);
			bit_strobe[ch] = 1'b0;
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	initial begin
		#80000;
		error_cnt++;
		wrap_up;
	end
	initial begin
		{rstn, tx_enable, bit_strobe, bit_data, bit_valid, eof_length} = '0;
		rx_enable = 1'b1;
		irq_enable = 8'h88;
		idle(8);
		rstn = 1'b1;
		chk_rd(8'h08, 8'h00);
		chk_rd(8'h0a, 8'h00);
		chk_rd(8'h09, 8'h00);
		chk_rd(8'h0b, 8'h00);
		chk_rd(8'h08, 8'h44);
		chk_rd(8'h0c, 8'h00);
		$display("reset test done");
		foreach (rows[r]) begin
			eof_length = rows[r].l;
			push(rows[r].ch, rows[r].dat, rows[r].vld, rows[r].n);
			idle(16);
			`CHK("irq", 1'b0, irq)
			if (rows[r].ch == 0) begin
				drx_host_model_i.read_a(st, dt, mk);
				`CHK("status", rows[r].st, st)
				`CHK("byte a", rows[r].byt, dt)
				`CHK("mask a", rows[r].msk, mk)
			end else begin
				chk_rd(8'h08, rows[r].st);
				chk_rd(8'h0b, rows[r].byt);
			end
			$display("row test done");
		end
		push(0, 8'h11, 8'hff, 8);
		push(0, 8'h22, 8'hff, 8);
		idle(16);
		chk_rd(8'h08, 8'h0d);
		chk_rd(8'h08, 8'h09);
		chk_rd(8'h09, 8'h22);
		drx_host_model_i.access(8'h09, 1'b0, d);
		chk_rd(8'h08, 8'h0c);
		$display("flow test done");
		irq_enable = 8'h01;
		push(0, 8'h5a, 8'hff, 8);
		idle(16);
		`CHK("irq", 1'b1, irq)
		tx_enable = 1'b1;
		chk_rd(8'h08, 8'h00);
		`CHK("irq", 1'b0, irq)
		tx_enable = 1'b0;
		drx_host_model_i.access(8'h08, 1'b1, d);
		chk_rd(8'h08, 8'h09);
		chk_rd(8'h09, 8'h5a);
		idle(2);
		`CHK("irq", 1'b0, irq)
		$display("irq test done");
		rx_enable = 1'b0;
		k = 0;
		repeat (6) begin
			@(negedge clk);
			k += bit_ready[0];
			bit_strobe[0] = 1'b1;
			bit_data[0] = 1'b1;
			bit_valid[0] = 1'b1;
		end
		@(negedge clk);
		bit_strobe[0] = 1'b0;
		rx_enable = 1'b1;
		`CHK("accepted", 4, k)
		push(0, 8'h00, 8'hff, 4);
		idle(16);
		chk_rd(8'h09, 8'h0f);
		$display("fifo test done");
		wrap_up;
	end
endmodule // dual_rx_serial_byte_packer_status_regs_tb
